// file: rtl/pidpc_top.sv
// Top of the PID process controller: APB register file, input synchronisers, limit flags.
// Assumes analog values arrive as samples already converted to tenths of a percent.
//
// The register addresses and the APB interface to the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
module pidpc_top #(
  parameter int SAMPLE_CYC = pidpc_pkg::SAMPLE_CYC
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Input terminals and analog inputs
  input wire logic [6:0] input_terminal,
  input wire logic [15:0] analog_in2,
  input wire logic [15:0] analog_in4,
  // Outputs
  output logic upper_limit_flag,
  output logic lower_limit_flag,
  output logic pid_active,
  output logic [15:0] freq_cmd
);
  typedef struct packed {
    logic [7:0] action_selection;
    logic [15:0] proportional_band_setting;
    logic [15:0] integral_time_setting;
    logic [15:0] upper_limit_setting;
    logic [15:0] lower_limit_setting;
    logic [15:0] set_point_setting;
    logic [15:0] derivative_time_setting;
    logic [15:0] user_group_read_select;
    logic [55:0] input_terminal_function_select;
    logic [15:0] max_freq;
    logic [15:0] min_freq;
    logic [6:0] term_s1;
    logic [6:0] term_s2;
    logic [15:0] an2_s1;
    logic [15:0] an2_s2;
    logic [15:0] an4_s1;
    logic [15:0] an4_s2;
    logic [31:0] div;
    logic sample;
    logic upper;
    logic lower;
    logic [31:0] rdata;
    logic slverr;
  } pidpc_top_s;

  pidpc_top_s st_q;
  pidpc_top_s st_d;
  logic pid_enable_input;
  logic en_assigned;
  logic action_ok;
  logic run;
  logic wr;
  logic rd;
  logic wr_ok;
  logic [15:0] meas;
  logic [15:0] sp;
  logic [15:0] wval;
  logic [15:0] status;

  pidpc_cfg_if cfg_if ();

  function automatic logic pid_action(input logic [7:0] code);
    pid_action = code == pidpc_pkg::ACT_REV20 || code == pidpc_pkg::ACT_FWD21 ||
      code == pidpc_pkg::ACT_REV50 || code == pidpc_pkg::ACT_FWD51 ||
      code == pidpc_pkg::ACT_REV60 || code == pidpc_pkg::ACT_FWD61;
  endfunction : pid_action

  function automatic logic [15:0] limit(input logic [15:0] v, input logic [15:0] lo, input logic [15:0] hi);
    limit = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction : limit

  // Each terminal with function code 14 feeds the PID enable input.
  logic [6:0] term_hit;
  genvar g;
  generate
    for (g = 0; g < pidpc_pkg::TERM_N; g++) begin : g_term
      assign term_hit[g] = st_q.input_terminal_function_select[g*8 +: 8] == pidpc_pkg::FUNC_PID_EN;
    end
  endgenerate

  assign en_assigned = |term_hit;
  assign pid_enable_input = |(term_hit & st_q.term_s2);
  assign action_ok = pid_action(st_q.action_selection);
  assign run = action_ok && (!en_assigned || pid_enable_input);

  // Full-scale input 4 already reads as 1000, i.e. 100%.
  assign meas = (st_q.an4_s2 > pidpc_pkg::PCT_FULL) ? pidpc_pkg::PCT_FULL : st_q.an4_s2;
  assign sp = (st_q.set_point_setting == pidpc_pkg::OFF_VAL) ?
    ((st_q.an2_s2 > pidpc_pkg::PCT_FULL) ? pidpc_pkg::PCT_FULL : st_q.an2_s2) :
    st_q.set_point_setting;

  assign wr = psel && penable && pwrite;
  assign rd = psel && !penable && !pwrite;
  // Settings are writable while running; only the user group select gates them.
  assign wr_ok = st_q.user_group_read_select == 16'h0000;
  assign wval = pwdata[15:0];
  assign status = {12'h000, en_assigned, st_q.lower, st_q.upper, run};

  assign cfg_if.band = st_q.proportional_band_setting;
  assign cfg_if.itime = st_q.integral_time_setting;
  assign cfg_if.dtime = st_q.derivative_time_setting;
  assign cfg_if.max_freq = st_q.max_freq;
  assign cfg_if.min_freq = st_q.min_freq;
  assign cfg_if.forward = st_q.action_selection[0];
  assign cfg_if.run = run;
  assign cfg_if.set_point = sp;
  assign cfg_if.measured = meas;
  assign cfg_if.sample = st_q.sample;

  always_comb begin
    st_d = st_q;
    st_d.term_s1 = input_terminal;
    st_d.term_s2 = st_q.term_s1;
    st_d.an2_s1 = analog_in2;
    st_d.an2_s2 = st_q.an2_s1;
    st_d.an4_s1 = analog_in4;
    st_d.an4_s2 = st_q.an4_s1;
    st_d.sample = 1'b0;
    if (st_q.div >= 32'(SAMPLE_CYC - 1)) begin
      st_d.div = '0;
      st_d.sample = 1'b1;
    end else begin
      st_d.div = st_q.div + 32'h00000001;
    end
    st_d.upper = run && st_q.upper_limit_setting != pidpc_pkg::OFF_VAL && meas > st_q.upper_limit_setting;
    st_d.lower = run && st_q.lower_limit_setting != pidpc_pkg::OFF_VAL && meas < st_q.lower_limit_setting;
    st_d.slverr = 1'b0;
    if (wr) begin
      unique case (paddr)
        pidpc_pkg::ADDR_UGROUP: st_d.user_group_read_select = wval;
        pidpc_pkg::ADDR_ACTION: if (wr_ok) begin
          st_d.action_selection = pwdata[7:0];
        end
        pidpc_pkg::ADDR_BAND: if (wr_ok && (wval == pidpc_pkg::OFF_VAL ||
          (wval >= pidpc_pkg::BAND_MIN && wval <= pidpc_pkg::BAND_MAX))) begin
          st_d.proportional_band_setting = wval;
        end
        pidpc_pkg::ADDR_ITIME: if (wr_ok && (wval == pidpc_pkg::OFF_VAL || wval <= pidpc_pkg::IT_MAX)) begin
          st_d.integral_time_setting = wval;
        end
        pidpc_pkg::ADDR_UPPER: if (wr_ok && (wval == pidpc_pkg::OFF_VAL || wval <= pidpc_pkg::PCT_FULL)) begin
          st_d.upper_limit_setting = wval;
        end
        pidpc_pkg::ADDR_LOWER: if (wr_ok && (wval == pidpc_pkg::OFF_VAL || wval <= pidpc_pkg::PCT_FULL)) begin
          st_d.lower_limit_setting = wval;
        end
        pidpc_pkg::ADDR_SETPT: if (wr_ok && (wval == pidpc_pkg::OFF_VAL || wval <= pidpc_pkg::PCT_FULL)) begin
          st_d.set_point_setting = wval;
        end
        pidpc_pkg::ADDR_DTIME: if (wr_ok && (wval == pidpc_pkg::OFF_VAL ||
          (wval >= pidpc_pkg::DT_MIN && wval <= pidpc_pkg::DT_MAX))) begin
          st_d.derivative_time_setting = wval;
        end
        pidpc_pkg::ADDR_TERMSEL: if (wr_ok) begin
          st_d.input_terminal_function_select = {pwdata[23:0], st_q.input_terminal_function_select[55:24]};
        end
        pidpc_pkg::ADDR_MAXFREQ: if (wr_ok) begin
          st_d.max_freq = wval;
        end
        pidpc_pkg::ADDR_MINFREQ: if (wr_ok) begin
          st_d.min_freq = limit(wval, 16'h0000, st_q.max_freq);
        end
        pidpc_pkg::ADDR_STATUS, pidpc_pkg::ADDR_FREQ: st_d.slverr = 1'b1;
        default: st_d.slverr = 1'b1;
      endcase
    end
    if (rd) begin
      unique case (paddr)
        pidpc_pkg::ADDR_ACTION: st_d.rdata = {24'h000000, st_q.action_selection};
        pidpc_pkg::ADDR_BAND: st_d.rdata = {16'h0000, st_q.proportional_band_setting};
        pidpc_pkg::ADDR_ITIME: st_d.rdata = {16'h0000, st_q.integral_time_setting};
        pidpc_pkg::ADDR_UPPER: st_d.rdata = {16'h0000, st_q.upper_limit_setting};
        pidpc_pkg::ADDR_LOWER: st_d.rdata = {16'h0000, st_q.lower_limit_setting};
        pidpc_pkg::ADDR_SETPT: st_d.rdata = {16'h0000, st_q.set_point_setting};
        pidpc_pkg::ADDR_DTIME: st_d.rdata = {16'h0000, st_q.derivative_time_setting};
        pidpc_pkg::ADDR_UGROUP: st_d.rdata = {16'h0000, st_q.user_group_read_select};
        pidpc_pkg::ADDR_TERMSEL: st_d.rdata = {8'h00, st_q.input_terminal_function_select[55:32]};
        pidpc_pkg::ADDR_STATUS: st_d.rdata = {16'h0000, status};
        pidpc_pkg::ADDR_FREQ: st_d.rdata = {16'h0000, cfg_if.freq};
        pidpc_pkg::ADDR_MAXFREQ: st_d.rdata = {16'h0000, st_q.max_freq};
        pidpc_pkg::ADDR_MINFREQ: st_d.rdata = {16'h0000, st_q.min_freq};
        default: st_d.rdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      st_q <= '0;
      st_q.proportional_band_setting <= pidpc_pkg::RST_BAND;
      st_q.integral_time_setting <= pidpc_pkg::RST_ITIME;
      st_q.upper_limit_setting <= pidpc_pkg::OFF_VAL;
      st_q.lower_limit_setting <= pidpc_pkg::OFF_VAL;
      st_q.set_point_setting <= pidpc_pkg::OFF_VAL;
      st_q.derivative_time_setting <= pidpc_pkg::OFF_VAL;
      st_q.max_freq <= pidpc_pkg::RST_MAXF;
      st_q.min_freq <= pidpc_pkg::RST_MINF;
    end else begin
      st_q <= st_d;
    end
  end

  // One wait-free APB answer; errors cover unmapped and read-only addresses on write.
  assign pready = 1'b1;
  assign prdata = st_q.rdata;
  assign pslverr = psel && penable && (pwrite ? !(paddr inside {pidpc_pkg::ADDR_ACTION, pidpc_pkg::ADDR_BAND,
    pidpc_pkg::ADDR_ITIME, pidpc_pkg::ADDR_UPPER, pidpc_pkg::ADDR_LOWER, pidpc_pkg::ADDR_SETPT,
    pidpc_pkg::ADDR_DTIME, pidpc_pkg::ADDR_UGROUP, pidpc_pkg::ADDR_TERMSEL, pidpc_pkg::ADDR_MAXFREQ,
    pidpc_pkg::ADDR_MINFREQ}) : 1'b0);

  assign upper_limit_flag = st_q.upper;
  assign lower_limit_flag = st_q.lower;
  assign pid_active = run;
  assign freq_cmd = cfg_if.freq;

  pidpc_core u_core (
    .clock(clock),
    .reset(reset),
    .cfg(cfg_if.core)
  );
endmodule : pidpc_top
`default_nettype wire

// file: include/pidpc_pkg.sv
// Package for the PID process controller: register map, field codes, reset values and timing.
// Assumes a 200 MHz clock and an APB slave with 32-bit data, one aligned word per register.
// Operation
// - PID runs only for action selection values 20, 21, 50, 51, 60, 61.
// - Function code 14 on any input terminal routes it to the PID enable input.
// - With no terminal assigned to PID enable, action selection alone enables PID.
// - Set point comes from stored setting 0..100%, or analog input 2 at 9999.
// - Measured process value comes from analog input 4.
// - Full-scale analog input 4 equals 100% for limit comparisons.
// - Lower limit flag while measured value is below setting; 9999 disables it.
// - Derivative time accepts 0.01 to 10.00 s; 9999 removes the derivative term.
// - Without derivative, output is proportional plus integral.
// - Without integral, output is proportional plus derivative.
// - With all terms, output is proportional plus integral plus derivative.
// - Reverse action: deviation is set point minus measured; positive raises frequency.
// - Forward action: negative deviation raises frequency, positive lowers it.
// - Band, integral time, set point and derivative time are writable while running.
// - PID settings are writable only when user group read select equals zero.
// - Upper limit flag while measured value exceeds setting; 9999 disables it.
// - Proportional gain is the reciprocal of the proportional band.
// - Action selection zero gives normal operation with no PID computation.
package pidpc_pkg;
  // Register byte offsets.
  localparam logic [7:0] ADDR_ACTION = 8'h00;
  localparam logic [7:0] ADDR_BAND = 8'h04;
  localparam logic [7:0] ADDR_ITIME = 8'h08;
  localparam logic [7:0] ADDR_UPPER = 8'h0C;
  localparam logic [7:0] ADDR_LOWER = 8'h10;
  localparam logic [7:0] ADDR_SETPT = 8'h14;
  localparam logic [7:0] ADDR_DTIME = 8'h18;
  localparam logic [7:0] ADDR_UGROUP = 8'h1C;
  localparam logic [7:0] ADDR_TERMSEL = 8'h20;
  localparam logic [7:0] ADDR_STATUS = 8'h24;
  localparam logic [7:0] ADDR_FREQ = 8'h28;
  localparam logic [7:0] ADDR_MAXFREQ = 8'h2C;
  localparam logic [7:0] ADDR_MINFREQ = 8'h30;

  localparam int ADDR_W = 8;
  localparam int TERM_N = 7;
  localparam int CODE_W = 8;
  localparam int VAL_W = 16;
  localparam int ACC_W = 32;

  // Disabled value shared by several settings.
  localparam logic [15:0] OFF_VAL = 16'h270F;
  // Percentages are tenths of a percent: 1000 is 100.0%.
  localparam logic [15:0] PCT_FULL = 16'h03E8;
  // Times are hundredths of a second.
  localparam logic [15:0] DT_MIN = 16'h0001;
  localparam logic [15:0] DT_MAX = 16'h03E8;
  localparam logic [15:0] IT_MAX = 16'h8CA0;
  localparam logic [15:0] BAND_MIN = 16'h0001;
  localparam logic [15:0] BAND_MAX = 16'h2710;

  localparam logic [7:0] ACT_NONE = 8'h00;
  localparam logic [7:0] ACT_REV20 = 8'h14;
  localparam logic [7:0] ACT_FWD21 = 8'h15;
  localparam logic [7:0] ACT_REV50 = 8'h32;
  localparam logic [7:0] ACT_FWD51 = 8'h33;
  localparam logic [7:0] ACT_REV60 = 8'h3C;
  localparam logic [7:0] ACT_FWD61 = 8'h3D;
  localparam logic [7:0] FUNC_PID_EN = 8'h0E;

  localparam logic [15:0] RST_BAND = 16'h03E8;
  localparam logic [15:0] RST_ITIME = 16'h0064;
  localparam logic [15:0] RST_MAXF = 16'h7530;
  localparam logic [15:0] RST_MINF = 16'h0000;

  // Status bit positions.
  localparam int ST_ACTIVE = 0;
  localparam int ST_UPPER = 1;
  localparam int ST_LOWER = 2;
  localparam int ST_ENASGN = 3;

  // Sample period of the loop: 10 ms, i.e. one hundredth of a second.
  localparam int CLK_HZ = 200000000;
  localparam int SAMPLE_US = 10000;
  localparam int SAMPLE_CYC = CLK_HZ / 1000000 * SAMPLE_US;
endpackage : pidpc_pkg

// file: include/pidpc_cfg_if.sv
// Interface carrying the stored settings from the register file to the loop core.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface pidpc_cfg_if;
  logic [15:0] band;
  logic [15:0] itime;
  logic [15:0] dtime;
  logic [15:0] max_freq;
  logic [15:0] min_freq;
  logic forward;
  logic run;
  logic [15:0] set_point;
  logic [15:0] measured;
  logic sample;
  logic [15:0] freq;
  modport regs (output band, itime, dtime, max_freq, min_freq, forward, run, set_point, measured, sample,
    input freq);
  modport core (input band, itime, dtime, max_freq, min_freq, forward, run, set_point, measured, sample,
    output freq);
endinterface : pidpc_cfg_if
`default_nettype wire

// file: rtl/pidpc_core.sv
// PID arithmetic core: one update per sample pulse, result clamped to the frequency range.
// Assumes settings are held stable by the register side between samples.
`timescale 1ns/1ps
`default_nettype none
module pidpc_core (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Settings and result
  pidpc_cfg_if.core cfg
);
  typedef struct packed {
    logic signed [31:0] integ;
    logic signed [16:0] prev_err;
    logic [15:0] freq;
  } pidpc_core_s;

  pidpc_core_s st_q;
  pidpc_core_s st_d;
  logic signed [16:0] err;
  logic signed [16:0] derr;
  logic signed [47:0] p_term;
  logic signed [47:0] i_term;
  logic signed [47:0] d_term;
  logic signed [47:0] sum;
  logic signed [47:0] band_s;
  logic signed [47:0] base;

  always_comb begin
    st_d = st_q;
    // Deviation is set point minus measured in both actions; forward action flips its effect.
    err = $signed({1'b0, cfg.set_point}) - $signed({1'b0, cfg.measured});
    if (cfg.forward) begin
      err = -err;
    end
    band_s = $signed({32'h0, cfg.band});
    // Gain is the reciprocal of the band; 1000 (100%) maps full deviation to full frequency.
    p_term = ($signed({{31{err[16]}}, err}) * $signed({32'h0, cfg.max_freq})) / band_s;
    if (cfg.band == pidpc_pkg::OFF_VAL) begin
      p_term = '0;
    end
    i_term = '0;
    if (cfg.itime != pidpc_pkg::OFF_VAL && cfg.itime != 16'h0000) begin
      i_term = ($signed({{16{st_q.integ[31]}}, st_q.integ}) * $signed({32'h0, cfg.max_freq}))
        / ($signed({32'h0, cfg.itime}) * band_s);
    end
    // The change of deviation has its own sign, which need not match that of the deviation.
    derr = err - st_q.prev_err;
    d_term = '0;
    if (cfg.dtime != pidpc_pkg::OFF_VAL) begin
      d_term = ($signed({{31{derr[16]}}, derr}) * $signed({32'h0, cfg.max_freq})
        * $signed({32'h0, cfg.dtime})) / band_s;
    end
    sum = p_term + i_term + d_term;
    base = $signed({32'h0, cfg.min_freq});
    if (!cfg.run) begin
      st_d.integ = '0;
      st_d.prev_err = '0;
      st_d.freq = cfg.min_freq;
    end else if (cfg.sample) begin
      st_d.integ = st_q.integ + 32'(signed'(err));
      st_d.prev_err = err;
      if (sum + base > $signed({32'h0, cfg.max_freq})) begin
        st_d.freq = cfg.max_freq;
      end else if (sum + base < base) begin
        st_d.freq = cfg.min_freq;
        st_d.integ = st_q.integ;
      end else begin
        st_d.freq = 16'(sum + base);
      end
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign cfg.freq = st_q.freq;
endmodule : pidpc_core
`default_nettype wire

// file: sim/pidpc_assertions.sv
// Checker for the PID controller top: tracks APB writes and watches the loop outputs.
// Assumes the frequency limit settings stay at their reset values throughout the run.
`timescale 1ns/1ps
`default_nettype none
module pidpc_assertions (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pslverr,
  // Outputs
  input wire logic upper_limit_flag,
  input wire logic lower_limit_flag,
  input wire logic pid_active,
  input wire logic [15:0] freq_cmd
);
  typedef struct packed {logic [7:0] act; logic lock;} pidpc_chk_s;
  pidpc_chk_s st_q;
  pidpc_chk_s st_d;
  logic wr;
  assign wr = psel && penable && pwrite;
  // The action code and the user group lock are mirrored; the bench writes nothing but valid codes to the action code.
  always_comb begin
    st_d = st_q;
    if (wr && paddr == pidpc_pkg::ADDR_UGROUP) begin
      st_d.lock = (pwdata[15:0] != 16'h0000);
    end
    if (wr && paddr == pidpc_pkg::ADDR_ACTION && !st_q.lock) begin
      st_d.act = pwdata[7:0];
    end
  end
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  property p_idle_zero; st_q.act == pidpc_pkg::ACT_NONE |-> !pid_active; endproperty
  a_idle_zero: assert property (p_idle_zero) else $error("pid active with action zero");
  property p_code;
    pid_active |-> st_q.act inside {8'h14, 8'h15, 8'h32, 8'h33, 8'h3C, 8'h3D};
  endproperty
  a_code: assert property (p_code) else $error("pid active with a non pid code");
  property p_upper; upper_limit_flag |-> pid_active || $past(pid_active); endproperty
  a_upper: assert property (p_upper) else $error("upper flag while idle");
  property p_lower; lower_limit_flag |-> pid_active || $past(pid_active); endproperty
  a_lower: assert property (p_lower) else $error("lower flag while idle");
  property p_idle_freq; (!pid_active) [*2] |-> freq_cmd == pidpc_pkg::RST_MINF; endproperty
  a_idle_freq: assert property (p_idle_freq) else $error("idle frequency not at minimum");
  property p_clamp; freq_cmd <= pidpc_pkg::RST_MAXF; endproperty
  a_clamp: assert property (p_clamp) else $error("frequency above maximum");
  property p_wr_ok; wr && paddr == pidpc_pkg::ADDR_BAND |-> !pslverr; endproperty
  a_wr_ok: assert property (p_wr_ok) else $error("band write refused");
  property p_wr_ro; wr && paddr == pidpc_pkg::ADDR_FREQ |-> pslverr; endproperty
  a_wr_ro: assert property (p_wr_ro) else $error("frequency write accepted");
  c_run: cover property ($rose(pid_active));
  c_up: cover property ($rose(upper_limit_flag));
  c_lo: cover property ($rose(lower_limit_flag));
endmodule : pidpc_assertions
`default_nettype wire

// file: sim/pidpc_proc_model.sv
// Process detector and set point source: drives analog inputs 2 and 4 and the terminals.
// Assumes the bench sets the wanted levels; the pins move only after a rising edge.
`timescale 1ns/1ps
`default_nettype none
module pidpc_proc_model (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Wanted levels
  input wire logic [15:0] sp_level,
  input wire logic [15:0] pv_level,
  input wire logic term_level,
  // Pins
  output logic [15:0] analog_in2,
  output logic [15:0] analog_in4,
  output logic [6:0] input_terminal
);
  // Every terminal follows one level, so the test does not hang on slot-to-pin mapping.
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      analog_in2 <= 16'h0;
      analog_in4 <= 16'h0;
      input_terminal <= 7'h0;
    end else begin
      analog_in2 <= sp_level;
      analog_in4 <= pv_level;
      input_terminal <= {7{term_level}};
    end
  end
endmodule : pidpc_proc_model
`default_nettype wire

// file: sim/tb_pidpc_top.sv
// Self-checking bench for the PID controller top, driven through APB and the process model.
// Assumes a shortened sample period; expectations are signs and orders, not exact gains.
`timescale 1ns/1ps
`default_nettype none
module tb_pidpc_top;
  localparam int SAMPLE = 20;
  logic clock, reset, psel, penable, pwrite, pready, pslverr, term_level, err;
  logic upper_limit_flag, lower_limit_flag, pid_active;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [6:0] input_terminal;
  logic [15:0] analog_in2, analog_in4, sp_level, pv_level, freq_cmd, f1;
  int bad_count, tests_run;
  logic [7:0] ra [8] = '{8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h2C, 8'h3C};
  logic [15:0] rv [8] = '{16'h03E8, 16'h0064, 16'h270F, 16'h270F, 16'h270F, 16'h270F, 16'h7530, 16'h0};
  logic [7:0] acts [8] = '{8'h00, 8'h14, 8'h15, 8'h32, 8'h33, 8'h3C, 8'h3D, 8'h00};
  logic [15:0] pvs [4] = '{16'h0384, 16'h0064, 16'h01F4, 16'hFFFF};
  logic [1:0] fl [4] = '{2'h2, 2'h1, 2'h0, 2'h2};
  pidpc_top #(.SAMPLE_CYC(SAMPLE)) dut (.clock(clock), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .input_terminal(input_terminal), .analog_in2(analog_in2), .analog_in4(analog_in4),
    .upper_limit_flag(upper_limit_flag), .lower_limit_flag(lower_limit_flag), .pid_active(pid_active),
    .freq_cmd(freq_cmd));
  pidpc_proc_model partner (.clock(clock), .reset(reset), .sp_level(sp_level), .pv_level(pv_level),
    .term_level(term_level), .analog_in2(analog_in2), .analog_in4(analog_in4),
    .input_terminal(input_terminal));
  initial begin
    clock = 1'h0;
    forever #2.5 clock = ~clock;
  end
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  // One idle cycle after each transfer keeps psel from being driven twice in a time step.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'h1;
    do @(posedge clock); while (pready !== 1'h1);
    err = pslverr;
    rd = prdata;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge clock);
  endtask : apb
  task automatic run_for(input int n);
    repeat (n * SAMPLE) @(posedge clock);
  endtask : run_for
  task automatic results();
    $display("Comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : results
  initial begin
    repeat (20000) @(posedge clock);
    bad_count++;
    $display("Error watchdog expired");
    results();
  end
  initial begin
    reset = 1'h1; psel = 1'h0; penable = 1'h0; pwrite = 1'h0; paddr = 8'h0; pwdata = 32'h0;
    sp_level = 16'h0; pv_level = 16'h0; term_level = 1'h0; bad_count = 0; tests_run = 0;
    repeat (6) @(posedge clock);
    reset <= 1'h0;
    @(posedge clock);
    foreach (ra[i]) begin
      apb(1'h0, ra[i], 32'h0);
      check("reset value", rd, {16'h0, rv[i]});
    end
    $display("Test reset values done");
    foreach (acts[i]) begin
      apb(1'h1, pidpc_pkg::ADDR_ACTION, {24'h0, acts[i]});
      check("pid_active", pid_active, acts[i] != 8'h00);
    end
    $display("Test action codes done");
    apb(1'h1, pidpc_pkg::ADDR_UGROUP, 32'h1);
    apb(1'h1, pidpc_pkg::ADDR_BAND, 32'h1F4);
    apb(1'h0, pidpc_pkg::ADDR_BAND, 32'h0);
    check("locked band", rd, 32'h3E8);
    apb(1'h1, pidpc_pkg::ADDR_UGROUP, 32'h0);
    apb(1'h1, pidpc_pkg::ADDR_ACTION, 32'h14);
    apb(1'h1, pidpc_pkg::ADDR_BAND, 32'h1F4);
    apb(1'h0, pidpc_pkg::ADDR_BAND, 32'h0);
    check("band while running", rd, 32'h1F4);
    apb(1'h1, pidpc_pkg::ADDR_BAND, 32'h3E8);
    apb(1'h1, pidpc_pkg::ADDR_FREQ, 32'h0);
    check("freq write error", err, 1'h1);
    $display("Test write access done");
    apb(1'h1, pidpc_pkg::ADDR_TERMSEL, 32'h0E);
    apb(1'h0, pidpc_pkg::ADDR_STATUS, 32'h0);
    check("enable assigned", rd[pidpc_pkg::ST_ENASGN], 1'h1);
    check("pid with terminal off", pid_active, 1'h0);
    term_level <= 1'h1;
    for (int i = 0; i < 50 && pid_active !== 1'h1; i++) @(posedge clock);
    check("pid with terminal on", pid_active, 1'h1);
    term_level <= 1'h0;
    repeat (3) apb(1'h1, pidpc_pkg::ADDR_TERMSEL, 32'h0);
    repeat (8) @(posedge clock);
    check("pid unassigned", pid_active, 1'h1);
    $display("Test enable input done");
    apb(1'h1, pidpc_pkg::ADDR_UPPER, 32'h320);
    apb(1'h1, pidpc_pkg::ADDR_LOWER, 32'hC8);
    foreach (pvs[i]) begin
      pv_level <= pvs[i];
      repeat (10) @(posedge clock);
      check("upper flag", upper_limit_flag, fl[i][1]);
      check("lower flag", lower_limit_flag, fl[i][0]);
    end
    apb(1'h1, pidpc_pkg::ADDR_UPPER, 32'h270F);
    apb(1'h1, pidpc_pkg::ADDR_LOWER, 32'h270F);
    pv_level <= 16'h0;
    repeat (10) @(posedge clock);
    check("lower flag off", lower_limit_flag, 1'h0);
    pv_level <= 16'h0384;
    repeat (10) @(posedge clock);
    check("upper flag off", upper_limit_flag, 1'h0);
    $display("Test limit flags done");
    pv_level <= 16'h012C;
    apb(1'h1, pidpc_pkg::ADDR_ITIME, 32'h270F);
    apb(1'h1, pidpc_pkg::ADDR_SETPT, 32'h2BC);
    run_for(5);
    check("reverse rises", freq_cmd > 16'h0, 1'h1);
    apb(1'h1, pidpc_pkg::ADDR_ITIME, 32'h64);
    f1 = freq_cmd;
    run_for(5);
    check("integral grows", freq_cmd > f1, 1'h1);
    apb(1'h1, pidpc_pkg::ADDR_ITIME, 32'h270F);
    apb(1'h1, pidpc_pkg::ADDR_ACTION, 32'h15);
    run_for(5);
    check("forward lowers", freq_cmd, 32'h0);
    apb(1'h1, pidpc_pkg::ADDR_ACTION, 32'h14);
    apb(1'h1, pidpc_pkg::ADDR_SETPT, 32'h270F);
    run_for(5);
    check("input 2 low", freq_cmd, 32'h0);
    apb(1'h1, pidpc_pkg::ADDR_DTIME, 32'h3E9);
    apb(1'h0, pidpc_pkg::ADDR_DTIME, 32'h0);
    check("dtime out of range", rd, 32'h270F);
    apb(1'h1, pidpc_pkg::ADDR_DTIME, 32'h1);
    sp_level <= 16'h02BC;
    for (int i = 0; i < 50 && freq_cmd == 16'h0; i++) @(posedge clock);
    check("derivative kick", freq_cmd, 32'h7530);
    run_for(5);
    check("input 2 high", freq_cmd > 16'h0, 1'h1);
    $display("Test loop direction done");
    results();
  end
endmodule : tb_pidpc_top
bind pidpc_top pidpc_assertions chk (.clock(clock), .reset(reset), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pslverr(pslverr), .upper_limit_flag(upper_limit_flag),
  .lower_limit_flag(lower_limit_flag), .pid_active(pid_active), .freq_cmd(freq_cmd));
`default_nettype wire
